//--- common/dadr_consts.vh
// Purpose: constants for the dma address and descriptor register set
// Assumes: byte-wide register port, four channels, 16 bytes per channel
// Notes:   subregister offsets are within one channel window
`ifndef DADR_CONSTS_VH
`define DADR_CONSTS_VH

// address split: [7:6] must be zero, [5:4] channel, [3:0] subregister
`define DADR_CH_MSB       5
`define DADR_CH_LSB       4
`define DADR_SUB_MSB      3

// subregister offsets inside a channel window
`define DADR_OFF_ADR_L    4'h0
`define DADR_OFF_ADR_M    4'h1
`define DADR_OFF_ADR_H    4'h2
`define DADR_OFF_SRC_L    4'h4
`define DADR_OFF_SRC_M    4'h5
`define DADR_OFF_SRC_H    4'h6
`define DADR_OFF_CDP_L    4'h8
`define DADR_OFF_CDP_H    4'h9
`define DADR_OFF_EDP_L    4'hA
`define DADR_OFF_EDP_H    4'hB
`define DADR_OFF_LEN_L    4'hC
`define DADR_OFF_LEN_H    4'hD
`define DADR_OFF_CTRL     4'hE
`define DADR_OFF_STAT     4'hF

// control byte fields
`define DADR_CTL_RUN      0
`define DADR_CTL_CHAIN    1
`define DADR_CTL_ABORT    2

// status byte fields (state bits 2:0 are the one-hot state)
`define DADR_ST_END       3
`define DADR_ST_BOF       4
`define DADR_ST_CHAIN     5

// reset values of control state
`define DADR_CTRL_RST     8'h00
`define DADR_ZERO_BYTE    8'h00

// address step sizes for byte and word memory cycles
`define DADR_STEP_BYTE    24'h00_0001
`define DADR_STEP_WORD    24'h00_0002

`endif

//--- rtl/dadr_addr_step.v
// Purpose: next memory address after one byte or word memory cycle
// Assumes: 24-bit flat address space, wraps at the top
// Notes:   purely combinational, one per channel
`include "dadr_consts.vh"

module dadr_addr_step
(
	input  wire [23:0] i_addr,
	input  wire        i_word,
	output wire [23:0] o_next
);

	// word cycles move two bytes, byte cycles one
	wire [23:0] step;

	assign step   = i_word ? `DADR_STEP_WORD : `DADR_STEP_BYTE;
	// carry out of bit 23 dropped on purpose: wraps in 16 Mbytes
	assign o_next = i_addr + step;

endmodule

//--- rtl/dadr_regs.v
// Purpose: address, descriptor and length registers of four dma channels
// Assumes: engine signals come from logic on i_mclk, no synchronisers
// Notes:   address and length registers are not reset; load before use
//
// Implementation choices: the strobed register port and the address map.
`include "dadr_consts.vh"

module dadr_regs
#(
	parameter NCH = 4
)
(
	input  wire            i_mclk,
	input  wire            i_sys_rst,
	input  wire [7:0]      i_addr,
	input  wire [7:0]      i_wdata,
	input  wire            i_wr,
	input  wire            i_rd,
	output reg  [7:0]      o_rdata,
	input  wire [NCH-1:0]  i_mem_cycle,
	input  wire [NCH-1:0]  i_word_xfer,
	input  wire [NCH-1:0]  i_buf_switch,
	input  wire [16*NCH-1:0] i_next_desc,
	input  wire [24*NCH-1:0] i_next_buf,
	input  wire [NCH-1:0]  i_serial_req,
	output wire [24*NCH-1:0] o_mem_addr,
	output wire [24*NCH-1:0] o_desc_addr,
	output wire [NCH-1:0]  o_chained,
	output wire [NCH-1:0]  o_enabled,
	output wire [NCH-1:0]  o_chain_end,
	output wire [NCH-1:0]  o_buf_error,
	output wire [NCH-1:0]  o_len_load,
	output wire [16*NCH-1:0] o_len_value
);

	// channel state codes, one-hot
	localparam [2:0] ST_INIT = 3'b001;
	localparam [2:0] ST_RUN  = 3'b010;
	localparam [2:0] ST_HALT = 3'b100;

	// decode: upper address bits must be zero, else unmapped
	wire            mapped;
	wire [3:0]      sub;
	wire [NCH-1:0]  ch_sel;
	wire [8*NCH-1:0] ch_rd;

	assign mapped = (i_addr[7:6] == 2'b00);
	assign sub    = i_addr[`DADR_SUB_MSB:0];
	assign ch_sel = mapped ?
		({{(NCH-1){1'b0}}, 1'b1} << i_addr[`DADR_CH_MSB:`DADR_CH_LSB]) :
		{NCH{1'b0}};

	genvar c;
	generate
		for (c = 0; c < NCH; c = c + 1)
		begin : g_ch
			localparam IS_RX = ((c % 2) == 0);

			reg  [2:0]  state;
			reg  [2:0]  next_state;
			reg         chain;
			reg  [23:0] adr;
			reg  [23:0] src;
			reg  [15:0] cdp;
			reg  [15:0] edp;
			reg  [7:0]  edp_lo_hold;
			reg  [7:0]  cdp_hi_hold;
			reg  [15:0] len;
			reg         bof;
			reg         end_pulse;
			reg         len_load;
			reg  [7:0]  rd_byte;
			wire        wr_ch;
			wire        rd_ch;
			wire        in_init;
			wire        running;
			wire        ptr_eq;
			wire        use_adr;
			wire [23:0] active;
			wire [23:0] stepped;
			wire [15:0] nd;
			wire        landing_end;
			assign wr_ch   = i_wr & ch_sel[c];
			assign rd_ch   = i_rd & ch_sel[c];
			assign in_init = state[0];
			assign running = state[1];
			assign ptr_eq  = (cdp == edp);
			assign nd      = i_next_desc[16*c +: 16];
			assign landing_end = running & chain & i_buf_switch[c] &
				(nd == edp);

			assign use_adr = chain | IS_RX;
			assign active  = use_adr ? adr : src;
			dadr_addr_step u_step
			(
				.i_addr (active),
				.i_word (i_word_xfer[c]),
				.o_next (stepped)
			);
			// state transitions: host run/abort, hardware end
			always @*
			begin
				next_state = state;
				case (state)
					ST_INIT:
						if (wr_ch && sub == `DADR_OFF_CTRL &&
							i_wdata[`DADR_CTL_RUN])
							next_state = ST_RUN;
					ST_RUN:
						if (landing_end)
							next_state = ST_INIT;
						else if (wr_ch && sub == `DADR_OFF_CTRL &&
							!i_wdata[`DADR_CTL_RUN])
							next_state = ST_HALT;
					ST_HALT:
						if (wr_ch && sub == `DADR_OFF_CTRL &&
							i_wdata[`DADR_CTL_ABORT])
							next_state = ST_INIT;
						else if (wr_ch && sub == `DADR_OFF_CTRL &&
							i_wdata[`DADR_CTL_RUN])
							next_state = ST_RUN;
					default:
						next_state = ST_INIT;
				endcase
			end

			// control state; with bof, the only reset flops of the channel
			always @(posedge i_mclk)
			begin
				if (i_sys_rst)
				begin
					state     <= ST_INIT;
					chain     <= 1'b0;
					end_pulse <= 1'b0;
					len_load  <= 1'b0;
				end
				else
				begin
					state     <= next_state;
					end_pulse <= landing_end;
					len_load  <= IS_RX & running & chain &
						i_buf_switch[c];
					// mode only changes while idle
					if (wr_ch && sub == `DADR_OFF_CTRL && in_init)
						chain <= i_wdata[`DADR_CTL_CHAIN];
				end
			end

			// sticky buffer error, set beats clear
			always @(posedge i_mclk)
			begin
				if (i_sys_rst)
					bof <= 1'b0;
				else if (i_serial_req[c] && running && chain && ptr_eq)
					bof <= 1'b1;
				else if (wr_ch && sub == `DADR_OFF_STAT &&
					i_wdata[`DADR_ST_BOF])
					bof <= 1'b0;
			end

			always @(posedge i_mclk)
			begin
				if (running && chain && i_buf_switch[c])
					adr <= i_next_buf[24*c +: 24];
				else if (running && use_adr && i_mem_cycle[c])
					adr <= stepped;
				else if (wr_ch && in_init && !chain)
				begin
					case (sub)
						`DADR_OFF_ADR_L: adr[7:0]   <= i_wdata;
						`DADR_OFF_ADR_M: adr[15:8]  <= i_wdata;
						`DADR_OFF_ADR_H: adr[23:16] <= i_wdata;
						default: adr <= adr;
					endcase
				end
			end

			// source address, its top byte doubles as descriptor base
			always @(posedge i_mclk)
			begin
				if (running && !use_adr && i_mem_cycle[c])
					src <= stepped;
				else if (wr_ch && in_init)
				begin
					case (sub)
						`DADR_OFF_SRC_L: src[7:0]   <= i_wdata;
						`DADR_OFF_SRC_M: src[15:8]  <= i_wdata;
						`DADR_OFF_SRC_H: src[23:16] <= i_wdata;
						default: src <= src;
					endcase
				end
			end

			// current descriptor pointer and its read capture
			always @(posedge i_mclk)
			begin
				if (running && chain && i_buf_switch[c])
					cdp <= nd;
				else if (wr_ch && in_init)
				begin
					case (sub)
						`DADR_OFF_CDP_L: cdp[7:0]  <= i_wdata;
						`DADR_OFF_CDP_H: cdp[15:8] <= i_wdata;
						default: cdp <= cdp;
					endcase
				end
				if (rd_ch && sub == `DADR_OFF_CDP_L)
					cdp_hi_hold <= cdp[15:8];
			end

			// end pointer writable at any time, paired halves
			always @(posedge i_mclk)
			begin
				if (wr_ch && sub == `DADR_OFF_EDP_L)
					edp_lo_hold <= i_wdata;
				if (wr_ch && sub == `DADR_OFF_EDP_H)
					edp <= {i_wdata, edp_lo_hold};
			end

			// length exists on receive channels only
			if (IS_RX)
			begin : g_len
				always @(posedge i_mclk)
				begin
					if (wr_ch && in_init)
					begin
						case (sub)
							`DADR_OFF_LEN_L: len[7:0]  <= i_wdata;
							`DADR_OFF_LEN_H: len[15:8] <= i_wdata;
							default: len <= len;
						endcase
					end
				end
			end
			else
			begin : g_nolen
				always @(posedge i_mclk)
					len <= 16'h0000;
			end

			// per channel read byte; missing registers read zero
			always @*
			begin
				case (sub)
					`DADR_OFF_ADR_L: rd_byte = adr[7:0];
					`DADR_OFF_ADR_M: rd_byte = adr[15:8];
					`DADR_OFF_ADR_H: rd_byte = adr[23:16];
					`DADR_OFF_SRC_L: rd_byte = src[7:0];
					`DADR_OFF_SRC_M: rd_byte = src[15:8];
					`DADR_OFF_SRC_H: rd_byte = src[23:16];
					`DADR_OFF_CDP_L: rd_byte = cdp[7:0];
					`DADR_OFF_CDP_H: rd_byte = cdp_hi_hold;
					`DADR_OFF_EDP_L: rd_byte = edp[7:0];
					`DADR_OFF_EDP_H: rd_byte = edp[15:8];
					`DADR_OFF_LEN_L: rd_byte = len[7:0];
					`DADR_OFF_LEN_H: rd_byte = len[15:8];
					`DADR_OFF_CTRL:
						rd_byte = {6'b00_0000, chain, running};
					`DADR_OFF_STAT:
						rd_byte = {2'b00, chain, bof, ptr_eq, state};
					default: rd_byte = `DADR_ZERO_BYTE;
				endcase
			end
			assign ch_rd[8*c +: 8] = rd_byte;
			// engine-facing outputs from flops, o_mem_addr through the adr/src mux (adr when chained or on receive channels)
			assign o_mem_addr[24*c +: 24]  = active;
			assign o_desc_addr[24*c +: 24] = {src[23:16], cdp};
			assign o_chained[c]   = chain;
			assign o_enabled[c]   = running;
			assign o_chain_end[c] = end_pulse;
			assign o_buf_error[c] = bof;
			assign o_len_load[c]  = len_load;
			assign o_len_value[16*c +: 16] = len;
		end
	endgenerate

	// read data stands in the cycle after the strobe only
	integer k;
	reg [7:0] next_rdata;
	always @*
	begin
		next_rdata = `DADR_ZERO_BYTE;
		for (k = 0; k < NCH; k = k + 1)
			if (ch_sel[k])
				next_rdata = ch_rd[8*k +: 8];
	end

	// unmapped addresses answer zero, never stall
	always @(posedge i_mclk)
	begin
		if (i_sys_rst || !i_rd)
			o_rdata <= `DADR_ZERO_BYTE;
		else
			o_rdata <= next_rdata;
	end

endmodule

//--- tb/dadr_regs_monitor.sv
// Purpose: port checks on the dma register set
// Assumes: one clock, synchronous reset
// Notes:   channel 0 watched for engine effects
module dadr_regs_monitor
#(
	parameter NCH = 4
)
(
	input wire              i_mclk,
	input wire              i_sys_rst,
	input wire [NCH-1:0]    i_mem_cycle,
	input wire [NCH-1:0]    i_word_xfer,
	input wire [NCH-1:0]    i_buf_switch,
	input wire [16*NCH-1:0] i_next_desc,
	input wire [24*NCH-1:0] i_next_buf,
	input wire [NCH-1:0]    i_serial_req,
	input wire [24*NCH-1:0] o_mem_addr,
	input wire [24*NCH-1:0] o_desc_addr,
	input wire [NCH-1:0]    o_chained,
	input wire [NCH-1:0]    o_enabled,
	input wire [NCH-1:0]    o_chain_end,
	input wire [NCH-1:0]    o_buf_error,
	input wire [NCH-1:0]    o_len_load,
	input wire [16*NCH-1:0] o_len_value
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (i_sys_rst);
	// switch that the channel must take
	wire sw0 = i_buf_switch[0] & o_enabled[0] & o_chained[0];

	desc_load_a:
	assert property (sw0 |=>
		o_desc_addr[15:0] == $past(i_next_desc[15:0]))
		else $error("descriptor pointer not loaded");
	base_keep_a:
	assert property (sw0 |=> $stable(o_desc_addr[23:16]))
		else $error("descriptor base changed");
	buf_load_a:
	assert property (sw0 |=>
		o_mem_addr[23:0] == $past(i_next_buf[23:0]))
		else $error("buffer address not loaded");
	addr_step_a:
	assert property (i_mem_cycle[0] & o_enabled[0] & !i_buf_switch[0]
		|=> o_mem_addr[23:0] == $past(o_mem_addr[23:0])
		+ ($past(i_word_xfer[0]) ? 24'h00_0002 : 24'h00_0001))
		else $error("address step wrong");
	len_load_a:
	assert property (sw0 |=> o_len_load[0])
		else $error("length reload missing");
	odd_len_a:
	assert property (o_len_load[1] == 1'b0 && o_len_load[3] == 1'b0
		&& o_len_value[31:16] == 16'h0000
		&& o_len_value[63:48] == 16'h0000)
		else $error("odd channel has length");
	chain_end_a:
	assert property (o_chain_end[0] |-> !o_enabled[0] && $past(sw0))
		else $error("chain end without switch");
	buf_err_a:
	assert property ($rose(o_buf_error[0]) |->
		$past(i_serial_req[0] & o_enabled[0] & o_chained[0]))
		else $error("buffer error without request");
	single_mode_a:
	assert property (!o_chained[0] |-> !o_len_load[0] && !o_chain_end[0])
		else $error("chain action in single mode");

	cover property (sw0);
	cover property (o_chain_end[0]);
	cover property ($rose(o_buf_error[0]));
endmodule

bind dadr_regs dadr_regs_monitor #(.NCH(NCH)) dadr_regs_monitor_inst
(
	.i_mclk, .i_sys_rst, .i_mem_cycle, .i_word_xfer, .i_buf_switch,
	.i_next_desc, .i_next_buf, .i_serial_req, .o_mem_addr, .o_desc_addr,
	.o_chained, .o_enabled, .o_chain_end, .o_buf_error, .o_len_load,
	.o_len_value
);

//--- tb/dadr_eng.sv
// Purpose: stand-in for transfer engine and serial requests
// Assumes: tasks entered just after a rising edge
// Notes:   qualifiers are scrambled once a pulse ends
module dadr_eng
(
	input  wire         i_mclk,
	output logic [3:0]  o_mc,
	output logic [3:0]  o_wx,
	output logic [3:0]  o_sw,
	output logic [3:0]  o_rq,
	output logic [63:0] o_nd,
	output logic [95:0] o_nb
);
	timeunit 1ns;
	timeprecision 1ns;
	initial
	begin
		{o_mc, o_wx, o_sw, o_rq, o_nd, o_nb} = '0;
	end
	// one memory cycle, byte or word
	task mc(input int c, input bit w);
	begin
		o_mc[c] <= 1'b1;
		o_wx[c] <= w;
		@(posedge i_mclk);
		o_mc[c] <= 1'b0;
		o_wx[c] <= ~w;
	end
	endtask
	task sw(input int c, input [15:0] d, input [23:0] b);
	begin
		o_sw[c] <= 1'b1;
		o_nd[c*16+:16] <= d;
		o_nb[c*24+:24] <= b;
		@(posedge i_mclk);
		o_sw[c] <= 1'b0;
		o_nd[c*16+:16] <= ~d;
		o_nb[c*24+:24] <= ~b;
	end
	endtask
	task rq(input int c);
	begin
		o_rq[c] <= 1'b1;
		@(posedge i_mclk);
		o_rq[c] <= 1'b0;
	end
	endtask
endmodule

//--- tb/dadr_regs_tb.sv
// Purpose: self-checking bench for the dma register set
// Assumes: engine model drives channel pulses
// Notes:   one idle cycle after each host access
module dadr_regs_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        i_mclk = 0;
	logic        i_sys_rst = 1;
	logic        i_wr = 0;
	logic        i_rd = 0;
	logic [7:0]  i_addr = 0;
	logic [7:0]  i_wdata = 0;
	wire  [7:0]  o_rdata;
	wire  [3:0]  mc, wx, sw, rq;
	wire  [63:0] nd;
	wire  [95:0] nb, o_mem_addr, o_desc_addr;
	wire  [63:0] ln_out;
	wire  [3:0]  en, chn;
	logic [23:0] ad [4], sr [4];
	logic [15:0] cd [4], ed [4], ln [4];
	int          n_mismatch = 0, comparisons = 0, seed = 62959, c, k;
	bit          w;

	always #25 i_mclk = ~i_mclk;
	dadr_eng dadr_eng_inst (.i_mclk, .o_mc(mc), .o_wx(wx), .o_sw(sw),
		.o_rq(rq), .o_nd(nd), .o_nb(nb));
	dadr_regs dadr_regs_inst (.i_mclk, .i_sys_rst, .i_addr, .i_wdata,
		.i_wr, .i_rd, .o_rdata, .i_mem_cycle(mc), .i_word_xfer(wx),
		.i_buf_switch(sw), .i_next_desc(nd), .i_next_buf(nb),
		.i_serial_req(rq), .o_mem_addr, .o_desc_addr, .o_chained(chn),
		.o_enabled(en), .o_chain_end(), .o_buf_error(), .o_len_load(),
		.o_len_value(ln_out));

	// expected address after one memory cycle
	function [23:0] stp(input [23:0] a, input bit w);
		stp = a + (w ? 24'h00_0002 : 24'h00_0001);
	endfunction
	// odd channels carry no length
	function [15:0] lexp(input int c);
		lexp = c[0] ? 16'h0000 : ln[c];
	endfunction
	task chk(input [23:0] g, input [23:0] e);
	begin
		comparisons++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("Error %0t: got %h want %h", $time, g, e);
		end
	end
	endtask
	task wr(input [7:0] a, input [7:0] d);
	begin
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_mclk);
		i_wr <= 1'b0;
		@(posedge i_mclk);
	end
	endtask
	// read data land in the cycle after the strobe
	task rd(input [7:0] a, input [7:0] e);
	begin
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_mclk);
		i_rd <= 1'b0;
		#1;
		chk(o_rdata, e);
		@(posedge i_mclk);
	end
	endtask
	task close_out;
	begin
		if (n_mismatch == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	end
	endtask

	initial
	begin
		repeat (8) @(posedge i_mclk);
		i_sys_rst <= 1'b0;
		// load all channels while idle, length never one
		for (c = 0; c < 4; c++)
		begin
			{ad[c], sr[c]} = {$random(seed), $random(seed)};
			{cd[c], ed[c]} = $random(seed);
			ln[c] = $random(seed) | 2;
			for (k = 0; k < 3; k++)
			begin
				wr(c * 16 + k, ad[c][8*k+:8]);
				wr(c * 16 + 4 + k, sr[c][8*k+:8]);
				if (k < 2)
				begin
					wr(c * 16 + 8 + k, cd[c][8*k+:8]);
					wr(c * 16 + 10 + k, ed[c][8*k+:8]);
					wr(c * 16 + 12 + k, ln[c][8*k+:8]);
				end
			end
		end
		for (c = 0; c < 4; c++)
		begin
			for (k = 0; k < 3; k++)
			begin
				rd(c * 16 + k, ad[c][8*k+:8]);
				rd(c * 16 + 4 + k, sr[c][8*k+:8]);
			end
			for (k = 0; k < 2; k++)
			begin
				rd(c * 16 + 10 + k, ed[c][8*k+:8]);
				rd(c * 16 + 12 + k, lexp(c) >> (8 * k));
			end
			rd(c * 16 + 8, cd[c][7:0]);
			rd(c * 16 + 9, cd[c][15:8]);
		end
		rd(8'h40, 8'h00);
		chk(ln_out[15:0], ln[0]);
		chk(ln_out[47:32], ln[2]);
		// receive and transmit channels both stepping
		wr(8'h0E, 8'h01);
		wr(8'h1E, 8'h01);
		for (k = 0; k < 24; k++)
		begin
			w = $random(seed);
			c = k % 2;
			dadr_eng_inst.mc(c, w);
			@(posedge i_mclk);
			if (c)
				sr[1] = stp(sr[1], w);
			else
				ad[0] = stp(ad[0], w);
		end
		chk(o_mem_addr[23:0], ad[0]);
		chk(o_mem_addr[47:24], sr[1]);
		// halted transmit channel ignores memory cycles, then resumes
		wr(8'h1E, 8'h00);
		rd(8'h1F, {4'h0, cd[1] == ed[1], 3'b100});
		dadr_eng_inst.mc(1, 0);
		@(posedge i_mclk);
		chk(o_mem_addr[47:24], sr[1]);
		wr(8'h1E, 8'h01);
		rd(8'h1E, 8'h01);
		// halt then abort back to idle, then chain
		wr(8'h0E, 8'h00);
		wr(8'h0E, 8'h04);
		wr(8'h08, 8'h00);
		wr(8'h09, 8'h10);
		wr(8'h0A, 8'h00);
		wr(8'h0B, 8'h30);
		wr(8'h0E, 8'h03);
		chk({chn, en}, 8'h13);
		wr(8'h00, 8'h55);
		rd(8'h00, ad[0][7:0]);
		wr(8'h0A, 8'h20);
		rd(8'h0A, 8'h00);
		wr(8'h0B, 8'h30);
		rd(8'h0A, 8'h20);
		rd(8'h08, 8'h00);
		dadr_eng_inst.sw(0, 16'h2000, 24'h12_3456);
		@(posedge i_mclk);
		rd(8'h09, 8'h10);
		chk(o_desc_addr[23:0], {sr[0][23:16], 16'h2000});
		dadr_eng_inst.rq(0);
		@(posedge i_mclk);
		rd(8'h0F, 8'h22);
		dadr_eng_inst.mc(0, 1);
		@(posedge i_mclk);
		chk(o_mem_addr[23:0], stp(24'h12_3456, 1));
		dadr_eng_inst.sw(0, 16'h3020, 24'h65_4321);
		@(posedge i_mclk);
		rd(8'h0F, 8'h29);
		wr(8'h0E, 8'h03);
		dadr_eng_inst.rq(0);
		@(posedge i_mclk);
		rd(8'h0F, 8'h3A);
		wr(8'h0F, 8'h10);
		rd(8'h0F, 8'h2A);
		close_out;
	end
	// watchdog well past the expected run length
	initial
	begin
		repeat (5000) @(posedge i_mclk);
		n_mismatch++;
		close_out;
	end
endmodule
